// File: src/digital_input_conditioner.sv
// digital input conditioner: scan, polarity, delays, logic and output latency
// What this block does
// - sample every input once per 5 ms
// - pin change reaches sample within one scan plus the two synchroniser flops
// - internal logic acts one scan later
// - direct output updates another scan later
// - per-input polarity, normally open by default
// - programmable activation delay, 1 ms steps
// - separate programmable drop-off delay, 1 ms steps
// - AC mode adds 30 ms deactivation delay
// - delays and polarity changeable at runtime
`timescale 1ns/10ps
module digital_input_conditioner
  import dic_pkg::*;
#(
  parameter int unsigned NUM_INPUTS = 3,
  parameter int unsigned SCAN_COUNT = SCAN_CYCLES
)
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [NUM_INPUTS-1:0] digital_input_n,
  input wire input_cfg_t [NUM_INPUTS-1:0] input_cfg,
  output logic [NUM_INPUTS-1:0] input_status,
  output logic [NUM_INPUTS-1:0] logic_status,
  output logic [NUM_INPUTS-1:0] digital_output_n,
  output logic scan_tick
);

  // elaboration check: the scan counter needs at least two cycles
  if (SCAN_COUNT < 2)
  begin : g_bad_scan
    $error("SCAN_COUNT must be at least 2");
  end
  // at least one input must be present
  if (NUM_INPUTS < 1)
  begin : g_bad_width
    $error("NUM_INPUTS must be at least 1");
  end
  // the delay fields must reach the longest programmable delay
  if (DELAY_W < $clog2(DELAY_MAX_MS + 1))
  begin : g_bad_delay
    $error("delay fields too narrow for the longest delay");
  end
  // the elapsed counter carries the longest wait, the ac extra and two scan steps
  if ((DELAY_W + 3) < $clog2(DELAY_MAX_MS + AC_RELEASE_MS + 2 * SCAN_PERIOD_US / DELAY_STEP_US))
  begin : g_bad_elapsed
    $error("elapsed counter too narrow");
  end
  // delays are counted in whole scans, so a scan must be whole delay steps
  if ((SCAN_PERIOD_US % DELAY_STEP_US) != 0)
  begin : g_bad_step
    $error("scan period is not a whole number of delay steps");
  end

  localparam int unsigned CNT_W = $clog2(SCAN_COUNT);
  localparam logic [CNT_W-1:0] SCAN_LAST = CNT_W'(SCAN_COUNT - 1);
  localparam int unsigned SCAN_MS = SCAN_PERIOD_US / DELAY_STEP_US;
  localparam logic [DELAY_W+2:0] SCAN_STEP_MS = (DELAY_W+3)'(SCAN_MS);
  localparam logic [DELAY_W+2:0] AC_EXTRA_MS = (DELAY_W+3)'(AC_RELEASE_MS);

  // latency budget, counted in scans of SCAN_COUNT cycles each:
  //   pin to sample     up to one scan, plus the two synchroniser flops
  //   sample to status  none with a zero delay, else ceil(delay / 5 ms) scans
  //   status to logic   one scan
  //   logic to output   one more scan
  // so a pin reaches the direct output within three scans plus the delay scans, and the relay
  // mechanics come on top of that.
  //
  // delays are counted in whole scans, so a programmed delay rounds up to
  // the next multiple of the scan; a finer 1 ms timer would buy nothing
  // while the pins are only looked at once per scan.
  //
  // settings are read only at a tick, so software may rewrite them at any
  // time; a change made between ticks takes hold at the next one, and a
  // pending wait is judged against the new value.

  // whole block state in one struct
  typedef struct packed {
    logic [CNT_W-1:0] scan_cnt;
    logic tick;
    chan_state_t [NUM_INPUTS-1:0] chan;
    logic [NUM_INPUTS-1:0] logic_out;
    logic [NUM_INPUTS-1:0] out_drive;
  } dic_state_t;

  dic_state_t state_q; // registered state
  dic_state_t state_d; // next state

  logic [NUM_INPUTS-1:0] pins_sync; // pins after two flops

  // field pins come from outside the clock domain
  sample_sync #(
    .WIDTH(NUM_INPUTS)
  ) u_sync (
    .core_clk(core_clk),
    .reset(reset),
    .pin_in(digital_input_n),
    .pin_sync(pins_sync)
  );

  // scan timing and per-input conditioning
  always_comb
  begin
    // hold everything unless a branch below moves it
    state_d = state_q;
    // the tick is a pulse of one cycle
    state_d.tick = 1'b0;
    // free-running scan divider, one tick per period
    if (state_q.scan_cnt == SCAN_LAST)
    begin
      state_d.scan_cnt = '0;
      state_d.tick = 1'b1;
    end
    else
    begin
      // count on towards the wrap
      state_d.scan_cnt = state_q.scan_cnt + CNT_W'(1);
    end

    // the pipeline below moves only on scan instants
    if (state_q.tick)
    begin
      // outputs follow logic one round behind
      state_d.out_drive = state_q.logic_out;
      for (int i = 0; i < NUM_INPUTS; i++)
      begin
        // logic sees the conditioned status one scan later
        state_d.logic_out[i] = state_q.chan[i].status;
      end
    end

    for (int i = 0; i < NUM_INPUTS; i++)
    begin
      logic sampled;
      logic [DELAY_W+2:0] need;
      logic [DELAY_W+2:0] base; // time already served by a pending change
      // defaults keep the loop free of stored values
      sampled = 1'b0;
      need = '0;
      base = '0;
      if (state_q.tick)
      begin
        // polarity: normally closed inverts the energised level
        sampled = pins_sync[i] ^ input_cfg[i].polarity_nc;
        state_d.chan[i].raw = sampled;
        // compare with the reported status, not with the last sample
        if (sampled == state_q.chan[i].status)
        begin
          // reverted or steady: any pending change is dropped
          state_d.chan[i].elapsed_ms = '0;
        end
        else
        begin
          // a fresh change starts its wait from zero, whatever is left over
          if (state_q.chan[i].raw == state_q.chan[i].status)
          begin
            base = '0;
          end
          else
          begin
            base = state_q.chan[i].elapsed_ms;
          end
          // the direction of the pending change picks its wait
          if (sampled)
          begin
            need = {3'b000, input_cfg[i].act_delay_ms};
          end
          else
          begin
            need = {3'b000, input_cfg[i].drop_delay_ms};
            // ac mode stretches the release only, never the pick-up
            if (input_cfg[i].ac_mode)
            begin
              need = need + AC_EXTRA_MS;
            end
          end
          // delay measured in whole scans, so it rounds up to a multiple of 5 ms
          if (base >= need)
          begin
            // wait served: the change lands and the timer starts afresh
            state_d.chan[i].status = sampled;
            state_d.chan[i].elapsed_ms = '0;
          end
          else
          begin
            // still waiting: one more scan has gone by
            state_d.chan[i].elapsed_ms = base + SCAN_STEP_MS;
          end
        end
      end
    end
  end

  // one register for the whole state
  // reset is synchronous and clears every field, outputs included
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      state_q <= '0;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  // every output is a flop
  always_comb
  begin
    for (int i = 0; i < NUM_INPUTS; i++)
    begin
      input_status[i] = state_q.chan[i].status;
    end
  end
  // logic and output stages are plain copies of registered fields
  assign logic_status = state_q.logic_out;
  assign digital_output_n = state_q.out_drive;
  assign scan_tick = state_q.tick;

endmodule : digital_input_conditioner

// File: src/dic_pkg.sv
// package: constants and carriers for the digital input conditioner
package dic_pkg;

  // timing
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned SCAN_PERIOD_US = 5000;
  localparam int unsigned SCAN_CYCLES = SCAN_PERIOD_US * (CLK_HZ / 1_000_000);
  localparam int unsigned DELAY_STEP_US = 1000;
  localparam int unsigned AC_RELEASE_MS = 30;
  localparam int unsigned DELAY_MAX_MS = 1_800_000;
  localparam int unsigned DELAY_W = 21;

  // values after reset
  localparam logic POLARITY_RESET = 1'b0;
  localparam logic AC_MODE_RESET = 1'b0;
  localparam logic [DELAY_W-1:0] DELAY_RESET = 21'h000000;

  // per-input settings written by software
  typedef struct packed {
    logic polarity_nc;
    logic ac_mode;
    logic [DELAY_W-1:0] act_delay_ms;
    logic [DELAY_W-1:0] drop_delay_ms;
  } input_cfg_t;

  // per-input conditioning state
  typedef struct packed {
    logic raw;
    logic status;
    logic [DELAY_W+2:0] elapsed_ms;
  } chan_state_t;

endpackage : dic_pkg

// File: src/sample_sync.sv
// two-flop synchroniser bank for field input pins
`timescale 1ns/10ps
module sample_sync
  import dic_pkg::*;
#(
  parameter int unsigned WIDTH = 3
)
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] pin_sync
);

  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } sync_state_t;

  sync_state_t state_q; // both stages
  sync_state_t state_d; // next value

  // the first stage feeds only the second
  always_comb
  begin
    state_d.meta = pin_in;
    state_d.stable = state_q.meta;
  end

  // plain capture, cleared on reset
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      state_q <= '0;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  assign pin_sync = state_q.stable;

endmodule : sample_sync

// File: tb/dic_asserts.sv
// checker: port-level scan timing of the input conditioner
`timescale 1ns/10ps
module dic_asserts
  import dic_pkg::*;
#(
  parameter int unsigned NUM_INPUTS = 3,
  parameter int unsigned SCAN_COUNT = 20
)
(
  input wire logic core_clk,
  input wire logic reset,
  input wire logic [NUM_INPUTS-1:0] digital_input_n,
  input wire input_cfg_t [NUM_INPUTS-1:0] input_cfg,
  input wire logic [NUM_INPUTS-1:0] input_status,
  input wire logic [NUM_INPUTS-1:0] logic_status,
  input wire logic [NUM_INPUTS-1:0] digital_output_n,
  input wire logic scan_tick
);
  localparam int GAP = SCAN_COUNT; // cycles from one tick to the next
  int unsigned since_tick; // cycles since the last tick
  logic seen_tick; // one tick has passed since reset
  // helper count: the scan period is far too long to unroll as a repetition
  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      since_tick <= 0;
      seen_tick <= 1'b0;
    end
    else if (scan_tick)
    begin
      since_tick <= 0;
      seen_tick <= 1'b1;
    end
    else
    begin
      since_tick <= since_tick + 1;
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  AST_TICK_GAP: assert property (scan_tick |=> !scan_tick [*8]) else $error("tick gap");
  AST_TICK_RECURS: assert property (seen_tick && since_tick == GAP - 1 |-> scan_tick)
    else $error("no tick");
  AST_TICK_PERIOD: assert property (scan_tick && seen_tick |-> since_tick == GAP - 1)
    else $error("tick early");
  AST_STATUS_AT_TICK: assert property (!$stable(input_status) |-> $past(scan_tick))
    else $error("status off tick");
  AST_LOGIC_AT_TICK: assert property (!$stable(logic_status) |-> $past(scan_tick))
    else $error("logic off tick");
  AST_LOGIC_LAG: assert property (scan_tick |=> logic_status == $past(input_status))
    else $error("logic lag");
  AST_OUT_AT_TICK: assert property (!$stable(digital_output_n) |-> $past(scan_tick))
    else $error("output off tick");
  AST_OUT_LAG: assert property (scan_tick |=> digital_output_n == $past(logic_status))
    else $error("output lag");
  AST_RESET_CLEAR: assert property ($fell(reset) |->
    !(|{input_status, logic_status, digital_output_n}))
    else $error("reset state");
  cover property (scan_tick);
  cover property ($rose(input_status[0]));
  cover property ($fell(digital_output_n[2]));
endmodule : dic_asserts
bind digital_input_conditioner dic_asserts #(.NUM_INPUTS(NUM_INPUTS), .SCAN_COUNT(SCAN_COUNT))
  u_asserts (.core_clk(core_clk), .reset(reset), .digital_input_n(digital_input_n),
  .input_cfg(input_cfg), .input_status(input_status), .logic_status(logic_status),
  .digital_output_n(digital_output_n), .scan_tick(scan_tick));

// File: tb/field_contacts.sv
// field contact model: energised levels reach the pins after settling
`timescale 1ns/10ps
module field_contacts
(
  input wire logic [2:0] energise,
  output logic [2:0] pin
);
  // settle well clear of the clock edge, as real contacts are unrelated to it
  initial pin = 3'h0;
  always @(energise) pin <= #37 energise;
endmodule : field_contacts

// File: tb/tb_digital_input_conditioner.sv
// testbench: scan latency, polarity, delays, ac mode and cancel
`timescale 1ns/10ps
module tb_digital_input_conditioner;
  import dic_pkg::*;
  localparam int SC = 20;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic [2:0] energise = 3'h0;
  logic [2:0] pins, st, ls, outs;
  logic scan_tick;
  input_cfg_t [2:0] cfg = '0;
  int n_errors = 0;
  int checked = 0;
  logic [7:0] lfsr = 8'h04;
  int m_el [3] = '{0, 0, 0}; // model: ms served by each pending change
  logic [2:0] m_st = 3'h0; // model: conditioned status
  logic [2:0] m_hist [$] = '{3'h0, 3'h0}; // model: statuses before the last two ticks
  bit cmp_due = 1'b0; // model moved at a tick, compare on the next falling edge
  always #50 core_clk = ~core_clk;
  field_contacts contacts (.energise(energise), .pin(pins));
  digital_input_conditioner #(.NUM_INPUTS(3), .SCAN_COUNT(SC)) dut (.core_clk(core_clk),
    .reset(reset), .digital_input_n(pins), .input_cfg(cfg), .input_status(st),
    .logic_status(ls), .digital_output_n(outs), .scan_tick(scan_tick));
  function automatic logic [7:0] nxt(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction : nxt
  task automatic close_out();
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : close_out
  task automatic chk(input string w, input bit ok, input logic [31:0] e, input logic [31:0] s);
    checked++;
    if (!ok)
    begin
      n_errors++;
      $display("[FAIL] %s exp %0d seen %0d", w, e, s);
    end
  endtask : chk
  // land on the falling edge just after the next tick, bounded
  task automatic wt();
    int k;
    k = 0;
    while (scan_tick !== 1'b1 && k < SC + 4)
    begin
      @(negedge core_clk);
      k++;
    end
    if (k >= SC + 4)
    begin
      chk("scan_tick", 1'b0, 1, 0);
      close_out();
    end
    @(negedge core_clk);
  endtask : wt
  // check: status settles after ceil(d/5) + 1 scans; the limit is d + 10 ms, or 5 ms when d is zero
  task automatic go(input int ch, input logic pv, input logic ev, input int d);
    int n;
    n = 0;
    wt();
    energise[ch] = pv;
    while (st[ch] !== ev && n < 400)
    begin
      wt();
      n++;
    end
    if (n >= 400)
    begin
      chk("status_wait", 1'b0, 32'(ev), 32'(st[ch]));
      close_out();
    end
    chk("latency", n * 5 >= d && n * 5 <= (d == 0 ? 5 : d + 10), d, n * 5);
  endtask : go
  // reference model: one update per scan, pins and settings read in the tick cycle
  always @(negedge core_clk)
  begin
    logic smp;
    int need;
    smp = 1'b0;
    need = 0;
    if (reset)
    begin
      m_st = 3'h0;
      m_hist = '{3'h0, 3'h0};
      m_el = '{0, 0, 0};
      cmp_due = 1'b0;
    end
    else if (cmp_due)
    begin
      cmp_due = 1'b0;
      chk("input_status", st === m_st, 32'(m_st), 32'(st));
      chk("logic_status", ls === m_hist[0], 32'(m_hist[0]), 32'(ls));
      chk("digital_output_n", outs === m_hist[1], 32'(m_hist[1]), 32'(outs));
    end
    else if (scan_tick === 1'b1)
    begin
      m_hist.push_front(m_st);
      void'(m_hist.pop_back());
      for (int i = 0; i < 3; i++)
      begin
        smp = pins[i] ^ cfg[i].polarity_nc;
        if (smp)
          need = int'(cfg[i].act_delay_ms);
        else
          need = int'(cfg[i].drop_delay_ms) + (cfg[i].ac_mode ? int'(AC_RELEASE_MS) : 0);
        if (smp == m_st[i])
          m_el[i] = 0;
        else if (m_el[i] >= need)
        begin
          m_st[i] = smp;
          m_el[i] = 0;
        end
        else
          m_el[i] = m_el[i] + int'(SCAN_PERIOD_US / DELAY_STEP_US);
      end
      cmp_due = 1'b1;
    end
  end
  initial
  begin
    int c;
    repeat (3) @(negedge core_clk);
    reset = 1'b0;
    wt();
    chk("status", st === 3'h0, 0, 32'(st));
    for (int i = 0; i < 6; i++)
    begin
      lfsr = nxt(lfsr);
      c = lfsr % 3;
      cfg[c].act_delay_ms = 21'(lfsr % 23);
      cfg[c].drop_delay_ms = 21'(lfsr % 17);
      cfg[c].ac_mode = lfsr[0];
      go(c, 1'b1, 1'b1, lfsr % 23);
      go(c, 1'b0, 1'b0, lfsr % 17 + (lfsr[0] ? 30 : 0));
      $display("test random %0d done", i);
    end
    cfg[1] = '0;
    cfg[1].polarity_nc = 1'b1;
    go(1, 1'b0, 1'b1, 0);
    go(1, 1'b1, 1'b0, 0);
    $display("test polarity done");
    cfg[2] = '0;
    cfg[2].act_delay_ms = 21'h000014;
    wt();
    energise[2] = 1'b1;
    wt();
    wt();
    energise[2] = 1'b0;
    repeat (8)
    begin
      wt();
      chk("cancel", st[2] === 1'b0, 0, 32'(st[2]));
    end
    go(2, 1'b1, 1'b1, 20);
    $display("test cancel done");
    close_out();
  end
endmodule : tb_digital_input_conditioner
